// >>> rtl/dbi_dac_regs.sv
`timescale 1ns/100ps
// Functional notes
// - enable-clear bit 0 disables underrun irq
// - set and clear views share enables
// - enable-set ones enable irqs, zeros ignored
// - reserved bits read zero
// - sync flag on busy fall, except enable/reset
// - buffer move to value sets empty flag
// - empty clears by w1c or buffer write
// - start event with empty buffer: underrun
// - flags clear by writing one
// - irq while flag and enable both set
// - status bit 7 tracks sync busy
// - value output from 9:0 or 15:6
// - buffer aligned like value register
// - enabled start event loads value, converts
// - soft reset clears all, wins write
// - enable reads back now, sets busy
module dbi_dac_regs (
	// clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_i,
	// apb slave
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [dbi_pkg::ADDR_W-1:0]  paddr_i,
	input  wire logic [dbi_pkg::DATA_W-1:0]  pwdata_i,
	output logic                             pready_o,
	output logic                             pslverr_o,
	output logic      [dbi_pkg::DATA_W-1:0]  prdata_o,
	// event system
	input  wire logic                        start_evt_i,
	output logic                             empty_evt_o,
	// converter side
	output logic      [dbi_pkg::CONV_W-1:0]  dac_value_o,
	output logic                             conv_start_o,
	output logic                             dac_enable_o,
	output dbi_pkg::dbi_outcfg_t             out_cfg_o,
	output logic                             irq_o
);
	import dbi_pkg::*;

	// state
	logic        main_enable;
	logic        main_stdby;
	logic        soft_reset_bit_pending;
	dbi_outcfg_t outcfg;
	logic        start_event_input_en;
	logic        empty_evt_en;
	dbi_irq_t    irq_en;
	dbi_irq_t    irq_flags;
	logic [15:0] conversion_value;
	logic [15:0] conversion_buffer;
	logic        buf_full;

	// synchroniser results
	logic      domain_sync_pending;
	logic      sync_done;
	dbi_kind_t sync_kind;

	// bus decode
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
		return (a[ADDR_W-1:6] == '0) && (a[5:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	wire logic access     = psel_i & penable_i;
	wire logic take       = access & pready_o;
	wire logic mapped     = reg_hit(paddr_i, IDX_MAIN) | reg_hit(paddr_i, IDX_OUTCFG) |
	                        reg_hit(paddr_i, IDX_EVCTRL) | reg_hit(paddr_i, IDX_IEN_CLR) |
	                        reg_hit(paddr_i, IDX_IEN_SET) | reg_hit(paddr_i, IDX_FLAGS) |
	                        reg_hit(paddr_i, IDX_STATUS) | reg_hit(paddr_i, IDX_VALUE) |
	                        reg_hit(paddr_i, IDX_BUFFER);
	wire logic wr         = take & pwrite_i & mapped;
	wire logic wr_main    = wr & reg_hit(paddr_i, IDX_MAIN);
	wire logic wr_outcfg  = wr & reg_hit(paddr_i, IDX_OUTCFG);
	wire logic wr_evctrl  = wr & reg_hit(paddr_i, IDX_EVCTRL);
	wire logic wr_ien_clr = wr & reg_hit(paddr_i, IDX_IEN_CLR);
	wire logic wr_ien_set = wr & reg_hit(paddr_i, IDX_IEN_SET);
	wire logic wr_flags   = wr & reg_hit(paddr_i, IDX_FLAGS);
	wire logic wr_value   = wr & reg_hit(paddr_i, IDX_VALUE);
	wire logic wr_buffer  = wr & reg_hit(paddr_i, IDX_BUFFER);
	wire dbi_irq_t wbits  = dbi_irq_t'(pwdata_i[2:0]);

	// soft reset wins over any other bit in the same write
	wire logic soft_reset_bit_wr   = wr_main & pwdata_i[MAIN_SOFT_RESET_BIT_BIT];
	wire logic en_wr      = wr_main & ~pwdata_i[MAIN_SOFT_RESET_BIT_BIT] &
	                        (pwdata_i[MAIN_EN_BIT] != main_enable);
	wire logic soft_clr   = sync_done & (sync_kind == KIND_SOFT_RESET_BIT);
	wire logic clr        = rst_i | soft_clr;

	// start event only acts while the converter and the input are enabled
	wire logic evt        = start_evt_i & start_event_input_en & main_enable;
	wire logic load       = evt & buf_full;
	wire logic underrun   = evt & ~buf_full;

	// value writes go through the converter domain too
	wire logic sync_start = soft_reset_bit_wr | en_wr | wr_value | wr_buffer;
	wire dbi_kind_t sync_kind_req = soft_reset_bit_wr ? KIND_SOFT_RESET_BIT :
	                                (en_wr ? KIND_ENABLE : KIND_DATA);
	wire logic sync_evt   = sync_done & (sync_kind == KIND_DATA);

	// flag sets, each beats a clear in the same cycle
	wire dbi_irq_t flag_set = '{sync_done: sync_evt, buf_empty: load, underrun: underrun};
	wire dbi_irq_t flag_clr = (wr_flags ? wbits : dbi_irq_t'(3'h0)) |
	                          dbi_irq_t'({1'b0, wr_buffer, 1'b0});
	wire dbi_irq_t next_flags = (irq_flags & ~flag_clr) | flag_set;
	wire dbi_irq_t next_en    = wr_ien_set ? (irq_en | wbits) :
	                            (wr_ien_clr ? (irq_en & ~wbits) : irq_en);

	// alignment of the ten converted bits
	wire logic [CONV_W-1:0] next_dac = outcfg.left_align ?
	                                   conversion_value[15:LEFT_LSB] :
	                                   conversion_value[CONV_W-1:0];

	// read mux; reserved bits are zero-filled
	wire logic [7:0] rd_main   = {5'h00, main_stdby, main_enable, soft_reset_bit_pending};
	wire logic [7:0] rd_outcfg = {outcfg.refsel, 1'b0, outcfg.bdwp, outcfg.vpd,
	                              outcfg.left_align, outcfg.ioen, outcfg.eoen};
	wire logic [7:0] rd_status = {domain_sync_pending, 7'h00};
	wire logic [DATA_W-1:0] rd_word =
		reg_hit(paddr_i, IDX_MAIN)    ? {24'h000000, rd_main} :
		reg_hit(paddr_i, IDX_OUTCFG)  ? {24'h000000, rd_outcfg} :
		reg_hit(paddr_i, IDX_EVCTRL)  ? {30'h0, empty_evt_en, start_event_input_en} :
		reg_hit(paddr_i, IDX_IEN_CLR) ? {29'h0, irq_en} :
		reg_hit(paddr_i, IDX_IEN_SET) ? {29'h0, irq_en} :
		reg_hit(paddr_i, IDX_FLAGS)   ? {29'h0, irq_flags} :
		reg_hit(paddr_i, IDX_STATUS)  ? {24'h000000, rd_status} :
		reg_hit(paddr_i, IDX_VALUE)   ? {16'h0000, conversion_value} :
		reg_hit(paddr_i, IDX_BUFFER)  ? {16'h0000, conversion_buffer} :
		32'h00000000;

	// apb response: one wait cycle, then a one-cycle pready
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= access & ~pready_o;
			pslverr_o <= access & ~pready_o & ~mapped;
			prdata_o  <= (access & ~pready_o & ~pwrite_i) ? rd_word : 32'h00000000;
		end
	end

	// control registers; soft reset returns them to reset values
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			main_enable          <= RST_BYTE[MAIN_EN_BIT];
			main_stdby           <= RST_BYTE[MAIN_STDBY_BIT];
			outcfg               <= dbi_outcfg_t'(RST_BYTE[6:0]);
			start_event_input_en <= RST_BYTE[EV_START_EVENT_INPUT_EN_BIT];
			empty_evt_en         <= RST_BYTE[EV_EMPTYEO_BIT];
		end else begin
			if (wr_main & ~pwdata_i[MAIN_SOFT_RESET_BIT_BIT]) begin
				main_enable <= pwdata_i[MAIN_EN_BIT];
				main_stdby  <= pwdata_i[MAIN_STDBY_BIT];
			end
			if (wr_outcfg) begin
				outcfg <= '{refsel: pwdata_i[OUT_REFSEL_LSB+:2], bdwp: pwdata_i[OUT_BDWP_BIT],
				            vpd: pwdata_i[OUT_VPD_BIT], left_align: pwdata_i[OUT_LEFT_BIT],
				            ioen: pwdata_i[OUT_IOEN_BIT], eoen: pwdata_i[OUT_EOEN_BIT]};
			end
			if (wr_evctrl) begin
				start_event_input_en <= pwdata_i[EV_START_EVENT_INPUT_EN_BIT];
				empty_evt_en         <= pwdata_i[EV_EMPTYEO_BIT];
			end
		end
	end

	// soft reset bit reads one until the converter side has finished
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			soft_reset_bit_pending <= 1'b0;
		end else if (soft_reset_bit_wr) begin
			soft_reset_bit_pending <= 1'b1;
		end
	end

	// interrupt enables and flags
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			irq_en    <= dbi_irq_t'(RST_BYTE[2:0]);
			irq_flags <= dbi_irq_t'(RST_BYTE[2:0]);
		end else begin
			irq_en    <= next_en;
			irq_flags <= next_flags;
		end
	end

	// data path: event load wins over a same-cycle value write
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			conversion_value  <= RST_HALF;
			conversion_buffer <= RST_HALF;
			buf_full          <= 1'b0;
		end else begin
			if (load) begin
				conversion_value <= conversion_buffer;
			end else if (wr_value) begin
				conversion_value <= pwdata_i[15:0];
			end
			if (wr_buffer) begin
				conversion_buffer <= pwdata_i[15:0];
			end
			buf_full <= wr_buffer | (buf_full & ~load);
		end
	end

	// registered outputs
	always_ff @(posedge sys_clk_i) begin
		if (clr) begin
			dac_value_o  <= RST_HALF[CONV_W-1:0];
			conv_start_o <= 1'b0;
			empty_evt_o  <= 1'b0;
			dac_enable_o <= 1'b0;
			out_cfg_o    <= dbi_outcfg_t'(RST_BYTE[6:0]);
			irq_o        <= 1'b0;
		end else begin
			dac_value_o  <= next_dac;
			conv_start_o <= load;
			empty_evt_o  <= load & empty_evt_en;
			dac_enable_o <= main_enable;
			out_cfg_o    <= outcfg;
			irq_o        <= |(next_flags & next_en);
		end
	end

	// converter-domain synchronisation timing
	dbi_sync_timer #(
		.CYCLES      (SYNC_CYCLES)
	) u_sync (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.start_i     (sync_start),
		.kind_i      (sync_kind_req),
		.busy_o      (domain_sync_pending),
		.done_o      (sync_done),
		.done_kind_o (sync_kind)
	);

	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// an accepted event that finds the buffer full
	sequence s_event_hit;
		(start_evt_i & start_event_input_en & main_enable & buf_full & ~soft_clr);
	endsequence

	a_underrun_flag: assert property (underrun & ~soft_clr |=> irq_flags.underrun)
		else $error("underrun flag not set");
	a_buf_load_move: assert property (s_event_hit |=>
		conversion_value == $past(conversion_buffer) && irq_flags.buf_empty && conv_start_o)
		else $error("buffer not moved on event");
	a_empty_clear: assert property (wr_buffer & ~load & ~soft_clr |=> !irq_flags.buf_empty)
		else $error("buffer write did not clear empty");
	a_flag_w1c: assert property (wr_flags && pwdata_i[IRQ_UNDERRUN_BIT] && !underrun
		|=> !irq_flags.underrun)
		else $error("flag not cleared by one");
	a_irq_level: assert property (irq_o == |(irq_flags & irq_en))
		else $error("irq output mismatch");
	a_enable_shared: assert property (wr_ien_clr && pwdata_i[IRQ_UNDERRUN_BIT] && !soft_clr
		|=> !irq_en.underrun)
		else $error("enable clear failed");
	a_enable_set: assert property (wr_ien_set && pwdata_i[IRQ_SYNC_BIT] && !soft_clr |=>
		irq_en.sync_done)
		else $error("enable set failed");
	a_busy_on_write: assert property (wr_value && !soft_clr |=>
		domain_sync_pending [*3] ##1 !domain_sync_pending)
		else $error("busy window wrong");
	a_sync_flag: assert property ($fell(domain_sync_pending) && sync_kind == KIND_DATA
		&& !sync_start |=> irq_flags.sync_done)
		else $error("sync ready flag missing");
	a_soft_reset_bit_clear: assert property (soft_reset_bit_wr ##1 !sync_start [*4] |=>
		!soft_reset_bit_pending && !main_enable && conversion_buffer == RST_HALF)
		else $error("soft reset incomplete");
	a_status_zero: assert property (rd_status[6:0] == 7'h00 && rd_main[7:3] == 5'h00)
		else $error("reserved bits nonzero");

endmodule

// >>> rtl/dbi_pkg.sv
package dbi_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_MAIN    = 4'h0;
	localparam logic [3:0] IDX_OUTCFG  = 4'h1;
	localparam logic [3:0] IDX_EVCTRL  = 4'h2;
	localparam logic [3:0] IDX_IEN_CLR = 4'h4;
	localparam logic [3:0] IDX_IEN_SET = 4'h5;
	localparam logic [3:0] IDX_FLAGS   = 4'h6;
	localparam logic [3:0] IDX_STATUS  = 4'h7;
	localparam logic [3:0] IDX_VALUE   = 4'h8;
	localparam logic [3:0] IDX_BUFFER  = 4'hc;

	// main_control fields
	localparam int unsigned MAIN_SOFT_RESET_BIT_BIT = 0;
	localparam int unsigned MAIN_EN_BIT    = 1;
	localparam int unsigned MAIN_STDBY_BIT = 2;

	// output_config fields
	localparam int unsigned OUT_EOEN_BIT   = 0;
	localparam int unsigned OUT_IOEN_BIT   = 1;
	localparam int unsigned OUT_LEFT_BIT   = 2;
	localparam int unsigned OUT_VPD_BIT    = 3;
	localparam int unsigned OUT_BDWP_BIT   = 4;
	localparam int unsigned OUT_REFSEL_LSB = 6;

	// event control fields
	localparam int unsigned EV_START_EVENT_INPUT_EN_BIT = 0;
	localparam int unsigned EV_EMPTYEO_BIT = 1;

	// interrupt bit positions, shared by enables and flags
	localparam int unsigned IRQ_UNDERRUN_BIT = 0;
	localparam int unsigned IRQ_EMPTY_BIT    = 1;
	localparam int unsigned IRQ_SYNC_BIT     = 2;

	// status field
	localparam int unsigned STATUS_BUSY_BIT = 7;

	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// conversion width and left-aligned offset
	localparam int unsigned CONV_W    = 10;
	localparam int unsigned LEFT_LSB  = 6;

	// converter-domain synchronisation length in bus clock cycles
	localparam int unsigned SYNC_CYCLES = 3;

	// interrupt sources, bit 2 down to bit 0
	typedef struct packed {
		logic sync_done;
		logic buf_empty;
		logic underrun;
	} dbi_irq_t;

	// output configuration, seven bits with no gap; refsel sits at bits 6:5
	typedef struct packed {
		logic [1:0] refsel;
		logic       bdwp;
		logic       vpd;
		logic       left_align;
		logic       ioen;
		logic       eoen;
	} dbi_outcfg_t;

	// what started a synchronisation
	typedef enum logic [1:0] {
		KIND_DATA   = 2'h0,
		KIND_ENABLE = 2'h1,
		KIND_SOFT_RESET_BIT  = 2'h2
	} dbi_kind_t;

	// synchroniser states, gray along idle-busy-end
	typedef enum logic [1:0] {
		SY_IDLE = 2'h0,
		SY_BUSY = 2'h1,
		SY_END  = 2'h3
	} dbi_sync_st_t;

endpackage

// >>> rtl/dbi_sync_timer.sv
`timescale 1ns/100ps
module dbi_sync_timer #(
	parameter int unsigned CYCLES = dbi_pkg::SYNC_CYCLES
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	// request
	input  wire logic             start_i,
	input  wire dbi_pkg::dbi_kind_t kind_i,
	// result
	output logic                  busy_o,
	output logic                  done_o,
	output dbi_pkg::dbi_kind_t    done_kind_o
);
	import dbi_pkg::*;

	dbi_sync_st_t  state;
	dbi_sync_st_t  next_state;
	logic [7:0]    cnt;
	logic [7:0]    next_cnt;
	dbi_kind_t     kind;

	localparam logic [7:0] LAST = 8'(CYCLES - 1);

	// a new request restarts the count so the latest write is the one that lands
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		unique case (state)
			SY_IDLE: begin
				next_cnt = 8'h00;
			end
			SY_BUSY: begin
				next_cnt = cnt + 8'h01;
				if (cnt == LAST) begin
					next_state = SY_END;
				end
			end
			SY_END: begin
				next_state = SY_IDLE;
				next_cnt   = 8'h00;
			end
			default: begin
				next_state = SY_IDLE;
				next_cnt   = 8'h00;
			end
		endcase
		if (start_i) begin
			next_state = SY_BUSY;
			next_cnt   = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= SY_IDLE;
			cnt   <= 8'h00;
			kind  <= KIND_DATA;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			if (start_i) begin
				kind <= kind_i;
			end
		end
	end

	assign busy_o      = (state == SY_BUSY);
	assign done_o      = (state == SY_END);
	assign done_kind_o = kind;

endmodule

// >>> test/dbi_dac_regs_tb_top.sv
`timescale 1ns/100ps
module dbi_dac_regs_tb_top;
	import dbi_pkg::*;

	logic                 sys_clk_i;
	logic                 rst_i;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata;
	logic                 pready;
	logic                 pslverr;
	logic [DATA_W-1:0]    prdata;
	logic                 start_evt;
	logic                 empty_evt;
	logic [CONV_W-1:0]    dac_value;
	logic                 conv_start;
	logic                 dac_enable;
	dbi_outcfg_t          out_cfg;
	logic                 irq;
	logic [31:0]          rd;
	logic                 er;
	int                   err_total;
	int                   n_checks;
	int                   m_ien;
	int                   m_flg;
	int                   m_val;
	int                   m_q[$];
	int                   v;
	logic [3:0]           reg_idx [9] = '{IDX_MAIN, IDX_OUTCFG, IDX_EVCTRL, IDX_IEN_CLR,
		IDX_IEN_SET, IDX_FLAGS, IDX_STATUS, IDX_VALUE, IDX_BUFFER};

	dbi_dac_regs dbi_dac_regs_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .start_evt_i(start_evt),
		.empty_evt_o(empty_evt), .dac_value_o(dac_value), .conv_start_o(conv_start),
		.dac_enable_o(dac_enable), .out_cfg_o(out_cfg), .irq_o(irq));

	dbi_partner dbi_partner_inst (.sys_clk_i(sys_clk_i), .pready_i(pready),
		.pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .start_evt_o(start_evt));

	// 25 mhz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	task automatic tally_and_finish();
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		dbi_partner_inst.xfer(1'b1, idx, d, rd, er);
	endtask

	task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic        e;
		dbi_partner_inst.xfer(1'b0, idx, 32'h0, d, e);
		chk(d, exp);
	endtask

	// polls status until busy drops; a hang is left to the watchdog
	task automatic waitsync();
		logic [31:0] d;
		logic        e;
		d = 32'h80;
		while (d[7] !== 1'b0) begin
			dbi_partner_inst.xfer(1'b0, IDX_STATUS, 32'h0, d, e);
		end
	endtask

	// event plus the model's view: load a held value or flag an underrun
	task automatic evt();
		dbi_partner_inst.pulse();
		if (m_q.size() > 0) begin
			m_val = m_q.pop_front();
			m_flg = m_flg | 2;
		end else begin
			m_flg = m_flg | 1;
		end
	endtask

	// watchdog, many times the expected run length
	initial begin
		#400000;
		err_total++;
		tally_and_finish();
	end

	initial begin
		rst_i = 1'b1;
		err_total = 0;
		n_checks = 0;
		m_ien = 0;
		m_flg = 0;
		m_val = 0;
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		// every register starts at zero
		foreach (reg_idx[i]) begin
			rdchk(reg_idx[i], 32'h0);
		end
		// unmapped address is refused
		dbi_partner_inst.xfer(1'b0, 4'h3, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
		// one enable state behind set and clear views
		wr(IDX_IEN_SET, 32'h7);
		m_ien = 7;
		rdchk(IDX_IEN_CLR, m_ien);
		wr(IDX_IEN_SET, 32'h0);
		rdchk(IDX_IEN_SET, m_ien);
		wr(IDX_IEN_CLR, 32'h1);
		m_ien = 6;
		rdchk(IDX_IEN_SET, m_ien);
		wr(IDX_IEN_CLR, 32'h0);
		rdchk(IDX_IEN_CLR, m_ien);
		// enable shows busy at once but its end raises no sync flag
		wr(IDX_MAIN, 32'h2);
		rdchk(IDX_STATUS, 32'h80);
		rdchk(IDX_MAIN, 32'h2);
		waitsync();
		rdchk(IDX_FLAGS, m_flg);
		chk({31'h0, dac_enable}, 32'h1);
		wr(IDX_EVCTRL, 32'h3);
		// right then left alignment, each with a load and an underrun
		for (int la = 0; la < 2; la++) begin
			wr(IDX_OUTCFG, la << 2);
			v = dbi_partner_inst.rnd() & 32'h3ff;
			m_q.push_back(v << (6 * la));
			wr(IDX_BUFFER, v << (6 * la));
			m_flg = (m_flg & 5) | 4;
			waitsync();
			rdchk(IDX_FLAGS, m_flg);
			evt();
			@(posedge sys_clk_i);
			chk({30'h0, conv_start, empty_evt}, 32'h3);
			@(posedge sys_clk_i);
			chk({22'h0, dac_value}, v);
			chk({31'h0, out_cfg.left_align}, la);
			rdchk(IDX_VALUE, m_val);
			evt();
			wr(IDX_FLAGS, 32'h0);
			rdchk(IDX_FLAGS, m_flg);
			chk({31'h0, irq}, 32'((m_flg & m_ien) != 0));
			// first pass keeps the empty flag for the next buffer write
			wr(IDX_FLAGS, 5 + 2 * la);
			m_flg = m_flg & ~(5 + 2 * la);
			rdchk(IDX_FLAGS, m_flg);
			chk({31'h0, irq}, 32'((m_flg & m_ien) != 0));
		end
		// direct value write goes through sync and raises the sync flag
		v = dbi_partner_inst.rnd() & 32'hffff;
		wr(IDX_VALUE, v);
		m_flg = m_flg | 4;
		waitsync();
		rdchk(IDX_VALUE, v);
		rdchk(IDX_FLAGS, m_flg);
		chk({22'h0, dac_value}, (v >> 6) & 32'h3ff);
		// soft reset beats the enable written alongside it
		wr(IDX_MAIN, 32'h3);
		waitsync();
		foreach (reg_idx[i]) begin
			rdchk(reg_idx[i], 32'h0);
		end
		chk({31'h0, dac_enable}, 32'h0);
		tally_and_finish();
	end
endmodule

// >>> test/dbi_partner.sv
`timescale 1ns/100ps
// apb master and start-event source standing in for cpu and event system
module dbi_partner (
	// clock
	input  wire logic                        sys_clk_i,
	// apb answer
	input  wire logic                        pready_i,
	input  wire logic                        pslverr_i,
	input  wire logic [dbi_pkg::DATA_W-1:0]  prdata_i,
	// apb request
	output logic                             psel_o,
	output logic                             penable_o,
	output logic                             pwrite_o,
	output logic      [dbi_pkg::ADDR_W-1:0]  paddr_o,
	output logic      [dbi_pkg::DATA_W-1:0]  pwdata_o,
	// event system
	output logic                             start_evt_o
);
	import dbi_pkg::*;

	int seed = 87515;

	// shared random source so the whole run repeats
	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction

	// quiet bus and no event at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = '0;
		pwdata_o = '0;
		start_evt_o = 1'b0;
	end

	// one transfer; request stands until pready is sampled high
	task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		@(posedge sys_clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= {2'h0, idx, 2'h0};
		pwdata_o <= d;
		@(posedge sys_clk_i);
		penable_o <= 1'b1;
		@(posedge sys_clk_i);
		while (pready_i !== 1'b1) begin
			@(posedge sys_clk_i);
		end
		rd = prdata_i;
		er = pslverr_i;
		// released lines carry noise so stale values never look valid
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwrite_o <= 1'(rnd());
		paddr_o <= 8'(rnd());
		pwdata_o <= rnd();
	endtask

	// single-cycle start-conversion event
	task automatic pulse();
		@(posedge sys_clk_i);
		start_evt_o <= 1'b1;
		@(posedge sys_clk_i);
		start_evt_o <= 1'b0;
	endtask
endmodule
